// ---- hw/tx_desc_dma.v ----
// Behaviour
// - A transmitter enable input stops new descriptor fetches and buffer reads when low, and lets them proceed when high.
// - The address the engine is reading frame data from is shown on an output.
// - The start address of the descriptor being processed is shown on an output.
// - The list base pointer is written by software and reads back as written, not as the current descriptor.
// - Each descriptor's chain flag selects chained traversal, and zero selects array traversal.
// - In chained mode the next descriptor address is the link word of the current one.
// - In array mode descriptors follow one another at a fixed stride and the link word is a second buffer address.
// - In array mode the next descriptor lies a programmable word gap past the end, zero meaning packed.
// - A fetched descriptor owned by the host suspends the engine without advancing.
// - A poll demand after software hands a descriptor over makes the suspended engine fetch it again.
// - A flush request discards everything held in the transmit FIFO.
// - A flush does not recall words already passed to the transmitter.
`timescale 1ns/100ps
`default_nettype none
`include "tx_dma_defs.vh"
module tx_desc_dma #(
   parameter FIFO_DEPTH_LOG2 = 4,
   parameter GAP_W = 5
) (
   input wire ref_clk_in, // 10 MHz system clock.
   input wire rst_in, // Synchronous reset, active high.
   input wire tx_enable_in, // Transmitter enable.
   input wire list_base_wr_in, // Write strobe for list base.
   input wire [31:0] list_base_in, // List base write data.
   input wire [GAP_W-1:0] descriptor_gap_words_in, // Array gap in words.
   input wire poll_demand_in, // Poll demand strobe.
   input wire flush_in, // FIFO flush strobe.
   output reg [31:0] tx_list_base_ptr_out, // List base readback.
   output reg [31:0] cur_desc_ptr_out, // Current descriptor address.
   output reg [31:0] cur_buf_ptr_out, // Current buffer read address.
   output reg suspended_out, // Engine suspended on host-owned descriptor.
   output reg mem_req_out, // Memory request.
   output reg mem_we_out, // Memory request is a write.
   output reg [31:0] mem_addr_out, // Memory byte address.
   output reg [31:0] mem_wdata_out, // Memory write data.
   input wire mem_ack_in, // Memory request done.
   input wire [31:0] mem_rdata_in, // Memory read data.
   output reg tx_valid_out, // Word to transmitter valid.
   output reg [31:0] tx_data_out, // Word to transmitter.
   output reg tx_last_out, // Last word of frame.
   input wire tx_ready_in // Transmitter takes word.
);
   localparam S_IDLE = 3'h0, S_CTRL = 3'h1, S_LEN = 3'h2, S_BUF = 3'h3;
   localparam S_LINK = 3'h4, S_DATA = 3'h5, S_WB = 3'h6, S_SUSP = 3'h7;
   reg [2:0] st_q;
   reg [31:0] ctrl_q, len_q, buf1_q, link_q;
   reg second_q;
   reg [12:0] left_q;
   reg run_q;
   wire fifo_ready, fifo_valid;
   // The FIFO carries the end-of-frame mark beside each word, so a flush drops both together.
   wire [32:0] fifo_data;
   wire data_ok = (st_q == S_DATA) && mem_req_out && mem_ack_in;
   wire chain = ctrl_q[`DESC_CHAIN_BIT];
   wire [13:0] len2 = {1'b0, len_q[`DESC_LEN2_LSB +: `DESC_LEN_W]};
   wire [31:0] stride = (`DESC_WORDS + {{(32-GAP_W){1'b0}}, descriptor_gap_words_in}) << 2;
   // A word closes the frame when its descriptor is marked last and no buffer of that descriptor remains.
   wire last_word = ctrl_q[`DESC_LAST_BIT] && (left_q <= 13'h0004) && (chain || second_q || len2 == 14'h0000);
   tx_byte_fifo #(.WIDTH(33), .DEPTH_LOG2(FIFO_DEPTH_LOG2)) fifo_u (
      .ref_clk_in(ref_clk_in),
      .rst_in(rst_in),
      .flush_in(flush_in),
      .wr_valid_in(data_ok),
      .wr_ready_out(fifo_ready),
      .wr_data_in({last_word, mem_rdata_in}),
      .rd_valid_out(fifo_valid),
      .rd_ready_in(!tx_valid_out || tx_ready_in),
      .rd_data_out(fifo_data)
   );
   always @(posedge ref_clk_in) begin
      if (rst_in) begin
         tx_valid_out <= 1'b0;
         tx_data_out <= 32'h0000_0000;
         tx_last_out <= 1'b0;
      end else if (!tx_valid_out || tx_ready_in) begin
         tx_valid_out <= fifo_valid;
         tx_data_out <= fifo_data[31:0];
         tx_last_out <= fifo_data[32];
      end
   end
   always @(posedge ref_clk_in) begin
      if (rst_in) begin
         tx_list_base_ptr_out <= `TX_LIST_BASE_RST;
      end else if (list_base_wr_in) begin
         tx_list_base_ptr_out <= list_base_in;
      end
   end
   always @(posedge ref_clk_in) begin
      if (rst_in) begin
         st_q <= S_IDLE;
         run_q <= 1'b0;
         cur_desc_ptr_out <= `TX_LIST_BASE_RST;
         cur_buf_ptr_out <= 32'h0000_0000;
         suspended_out <= 1'b0;
         mem_req_out <= 1'b0;
         mem_we_out <= 1'b0;
         mem_addr_out <= 32'h0000_0000;
         mem_wdata_out <= 32'h0000_0000;
         ctrl_q <= 32'h0000_0000;
         len_q <= 32'h0000_0000;
         buf1_q <= 32'h0000_0000;
         link_q <= 32'h0000_0000;
         second_q <= 1'b0;
         left_q <= 13'h0000;
      end else begin
         if (list_base_wr_in) begin
            run_q <= 1'b0;
            // A busy engine keeps its pointer, since the write-back of the current descriptor still needs it.
            if (st_q == S_IDLE || st_q == S_SUSP) begin
               cur_desc_ptr_out <= list_base_in;
            end
         end
         if (mem_req_out && mem_ack_in) begin
            mem_req_out <= 1'b0;
         end
         case (st_q)
            S_IDLE: begin
               if (tx_enable_in && !list_base_wr_in && !mem_req_out) begin
                  st_q <= S_CTRL;
                  mem_req_out <= 1'b1;
                  mem_we_out <= 1'b0;
                  mem_addr_out <= cur_desc_ptr_out + `DESC_CTRL_OFS;
                  if (!run_q) begin
                     cur_desc_ptr_out <= tx_list_base_ptr_out;
                     mem_addr_out <= tx_list_base_ptr_out + `DESC_CTRL_OFS;
                     run_q <= 1'b1;
                  end
               end
            end
            S_CTRL: if (mem_ack_in) begin
               ctrl_q <= mem_rdata_in;
               if (!mem_rdata_in[`DESC_OWN_BIT]) begin
                  st_q <= S_SUSP;
                  suspended_out <= 1'b1;
               end else begin
                  st_q <= S_LEN;
                  mem_req_out <= 1'b1;
                  mem_addr_out <= cur_desc_ptr_out + `DESC_LEN_OFS;
               end
            end
            S_LEN: if (mem_ack_in) begin
               len_q <= mem_rdata_in;
               st_q <= S_BUF;
               mem_req_out <= 1'b1;
               mem_addr_out <= cur_desc_ptr_out + `DESC_BUF1_OFS;
            end
            S_BUF: if (mem_ack_in) begin
               buf1_q <= mem_rdata_in;
               st_q <= S_LINK;
               mem_req_out <= 1'b1;
               mem_addr_out <= cur_desc_ptr_out + `DESC_LINK_OFS;
            end
            S_LINK: if (mem_ack_in) begin
               link_q <= mem_rdata_in;
               second_q <= 1'b0;
               cur_buf_ptr_out <= buf1_q;
               left_q <= len_q[`DESC_LEN1_LSB +: `DESC_LEN_W];
               st_q <= S_DATA;
            end
            S_DATA: begin
               if (data_ok) begin
                  cur_buf_ptr_out <= cur_buf_ptr_out + 32'h0000_0004;
                  left_q <= (left_q > 13'h0004) ? left_q - 13'h0004 : 13'h0000;
               end else if (!mem_req_out) begin
                  if (left_q != 13'h0000) begin
                     if (tx_enable_in && fifo_ready) begin
                        mem_req_out <= 1'b1;
                        mem_addr_out <= cur_buf_ptr_out;
                     end
                  end else if (!chain && !second_q && len2 != 14'h0000) begin
                     second_q <= 1'b1;
                     cur_buf_ptr_out <= link_q;
                     left_q <= len2[12:0];
                  end else begin
                     st_q <= S_WB;
                     mem_req_out <= 1'b1;
                     mem_we_out <= 1'b1;
                     mem_addr_out <= cur_desc_ptr_out + `DESC_CTRL_OFS;
                     mem_wdata_out <= ctrl_q & ~(32'h0000_0001 << `DESC_OWN_BIT);
                  end
               end
            end
            S_WB: if (mem_ack_in) begin
               mem_we_out <= 1'b0;
               st_q <= S_IDLE;
               if (chain) begin
                  cur_desc_ptr_out <= link_q;
               end else begin
                  cur_desc_ptr_out <= cur_desc_ptr_out + stride;
               end
            end
            S_SUSP: begin
               if (poll_demand_in) begin
                  suspended_out <= 1'b0;
                  st_q <= S_IDLE;
               end
            end
            default: st_q <= S_IDLE;
         endcase
      end
   end
endmodule // tx_desc_dma
`default_nettype wire

// ---- hw/tx_dma_defs.vh ----
`ifndef TX_DMA_DEFS_VH
`define TX_DMA_DEFS_VH
// Descriptor layout: four 32-bit words, addressed by byte.
`define DESC_WORDS 4
`define DESC_CTRL_OFS 32'h0000_0000
`define DESC_LEN_OFS 32'h0000_0004
`define DESC_BUF1_OFS 32'h0000_0008
`define DESC_LINK_OFS 32'h0000_000c
// Control word fields.
`define DESC_OWN_BIT 31
`define DESC_LAST_BIT 29
`define DESC_CHAIN_BIT 20
// Length word fields: buffer 1 in [12:0], buffer 2 in [28:16].
`define DESC_LEN1_LSB 0
`define DESC_LEN2_LSB 16
`define DESC_LEN_W 13
// Reset values.
`define TX_LIST_BASE_RST 32'h0000_0000
`define TX_GAP_RST 5'h00
`endif

// ---- hw/tx_byte_fifo.v ----
`timescale 1ns/100ps
`default_nettype none
module tx_byte_fifo #(
   parameter WIDTH = 32,
   parameter DEPTH_LOG2 = 4
) (
   input wire ref_clk_in, // System clock.
   input wire rst_in, // Synchronous reset.
   input wire flush_in, // Discard all held words.
   input wire wr_valid_in, // Write word valid.
   output wire wr_ready_out, // Room for a word.
   input wire [WIDTH-1:0] wr_data_in, // Write word.
   output wire rd_valid_out, // Word available.
   input wire rd_ready_in, // Reader takes word.
   output wire [WIDTH-1:0] rd_data_out // Head word.
);
   localparam DEPTH = 1 << DEPTH_LOG2;
   reg [WIDTH-1:0] mem_q [0:DEPTH-1];
   reg [DEPTH_LOG2:0] wp_q;
   reg [DEPTH_LOG2:0] rp_q;
   wire full = (wp_q[DEPTH_LOG2] != rp_q[DEPTH_LOG2]) &&
               (wp_q[DEPTH_LOG2-1:0] == rp_q[DEPTH_LOG2-1:0]);
   wire empty = (wp_q == rp_q);
   assign wr_ready_out = !full && !flush_in;
   assign rd_valid_out = !empty && !flush_in;
   assign rd_data_out = mem_q[rp_q[DEPTH_LOG2-1:0]];
   always @(posedge ref_clk_in) begin
      if (wr_valid_in && wr_ready_out) begin
         mem_q[wp_q[DEPTH_LOG2-1:0]] <= wr_data_in;
      end
   end
   always @(posedge ref_clk_in) begin
      if (rst_in || flush_in) begin
         wp_q <= {(DEPTH_LOG2+1){1'b0}};
         rp_q <= {(DEPTH_LOG2+1){1'b0}};
      end else begin
         if (wr_valid_in && wr_ready_out) begin
            wp_q <= wp_q + 1'b1;
         end
         if (rd_valid_out && rd_ready_in) begin
            rp_q <= rp_q + 1'b1;
         end
      end
   end
endmodule // tx_byte_fifo
`default_nettype wire

// ---- verification/tx_desc_dma_assertions.sv ----
`timescale 1ns/100ps
`default_nettype none
module tx_desc_dma_chk (
   input wire ref_clk_in, // Clock.
   input wire rst_in, // Reset.
   input wire list_base_wr_in, // Base strobe.
   input wire [31:0] list_base_in, // Base data.
   input wire poll_demand_in, // Poll.
   input wire [31:0] tx_list_base_ptr_out, // Base readback.
   input wire [31:0] cur_desc_ptr_out, // Descriptor.
   input wire suspended_out, // Suspended.
   input wire mem_req_out, // Request.
   input wire mem_we_out, // Write.
   input wire [31:0] mem_addr_out, // Address.
   input wire [31:0] mem_wdata_out, // Write data.
   input wire mem_ack_in, // Ack.
   input wire tx_valid_out, // Tx valid.
   input wire [31:0] tx_data_out, // Tx word.
   input wire tx_ready_in // Tx ready.
);
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (rst_in);
   base_readback_a: assert property (list_base_wr_in |=> tx_list_base_ptr_out == $past(list_base_in))
      else $error("base readback wrong");
   req_hold_a: assert property (mem_req_out && !mem_ack_in |=> mem_req_out && $stable(mem_addr_out))
      else $error("request dropped early");
   req_gap_a: assert property (mem_req_out && mem_ack_in && mem_we_out |=> !mem_req_out)
      else $error("request right after write-back");
   wb_addr_a: assert property (mem_req_out && mem_we_out |-> mem_addr_out == cur_desc_ptr_out)
      else $error("write-back misses descriptor");
   tx_hold_a: assert property (tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_data_out))
      else $error("held word lost");
   owner_return_a: assert property (mem_req_out && mem_we_out |-> !mem_wdata_out[31])
      else $error("write-back keeps ownership");
   suspend_quiet_a: assert property (suspended_out && !poll_demand_in && !list_base_wr_in |=> !mem_req_out)
      else $error("suspended engine reads");
   suspend_cause_a: assert property ($rose(suspended_out) |-> $past(mem_ack_in))
      else $error("suspend without fetch");
   reset_quiet_a: assert property ($fell(rst_in) |-> !mem_req_out && !suspended_out && !tx_valid_out)
      else $error("outputs busy after reset");
   cover property ($rose(suspended_out));
   cover property (mem_req_out && mem_we_out && mem_ack_in);
   cover property (poll_demand_in && suspended_out);
endmodule // tx_desc_dma_chk
bind tx_desc_dma tx_desc_dma_chk u_chk (.ref_clk_in, .rst_in, .list_base_wr_in, .list_base_in, .poll_demand_in,
   .tx_list_base_ptr_out, .cur_desc_ptr_out, .suspended_out, .mem_req_out, .mem_we_out, .mem_addr_out,
   .mem_wdata_out, .mem_ack_in, .tx_valid_out, .tx_data_out, .tx_ready_in);
`default_nettype wire

// ---- verification/tx_mem_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module tx_mem_model (
   input wire ref_clk_in, // Clock.
   input wire [1:0] wait_in, // Extra wait cycles.
   input wire req_in, // Request.
   input wire we_in, // Write.
   input wire [31:0] addr_in, // Byte address.
   input wire [31:0] wdata_in, // Write data.
   output logic ack_out, // Done.
   output logic [31:0] rdata_out // Read data.
);
   logic [31:0] mem [0:255];
   logic [1:0] cnt = 2'h0;
   initial ack_out = 1'b0;
   initial rdata_out = 32'h0;
   // Read data toggles outside an answer so a stale word is never mistaken for a valid one.
   always @(posedge ref_clk_in) begin
      ack_out <= 1'b0;
      rdata_out <= ~rdata_out;
      if (req_in && !ack_out) begin
         cnt <= cnt + 2'h1;
         if (cnt >= wait_in) begin
            ack_out <= 1'b1;
            cnt <= 2'h0;
            rdata_out <= mem[addr_in[9:2]];
            if (we_in) begin
               mem[addr_in[9:2]] <= wdata_in;
            end
         end
      end
   end
endmodule // tx_mem_model
`default_nettype wire

// ---- verification/tx_desc_dma_tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module tx_desc_dma_tb_top;
   logic ref_clk_in = 1'b0, rst_in = 1'b1, tx_enable_in = 1'b0, list_base_wr_in = 1'b0, poll = 1'b0, flush = 1'b0;
   logic [31:0] list_base_in = 32'h0, base_q, cur_desc, cur_buf, maddr, mwdata, rdata, tx_data;
   logic [4:0] gap = 5'h02;
   logic tx_ready = 1'b1, susp, mreq, mwe, ack, tx_valid, tx_last;
   logic [1:0] wt = 2'h0;
   logic [31:0] got_q[$];
   logic [31:0] rd_q[$];
   logic last_q[$];
   int bad_count = 0, tests_run = 0, cyc = 0;
   always #50 ref_clk_in = ~ref_clk_in;
   tx_desc_dma u_tx_desc_dma (.ref_clk_in, .rst_in, .tx_enable_in, .list_base_wr_in, .list_base_in,
      .descriptor_gap_words_in(gap), .poll_demand_in(poll), .flush_in(flush), .tx_list_base_ptr_out(base_q),
      .cur_desc_ptr_out(cur_desc), .cur_buf_ptr_out(cur_buf), .suspended_out(susp), .mem_req_out(mreq),
      .mem_we_out(mwe), .mem_addr_out(maddr), .mem_wdata_out(mwdata), .mem_ack_in(ack), .mem_rdata_in(rdata),
      .tx_valid_out(tx_valid), .tx_data_out(tx_data), .tx_last_out(tx_last), .tx_ready_in(tx_ready));
   tx_mem_model u_tx_mem_model (.ref_clk_in, .wait_in(wt), .req_in(mreq), .we_in(mwe), .addr_in(maddr),
      .wdata_in(mwdata), .ack_out(ack), .rdata_out(rdata));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up();
      $display("Checks %0d, mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic desc(input logic [31:0] a, c, l, b, k);
      u_tx_mem_model.mem[a[9:2]] = c;
      u_tx_mem_model.mem[a[9:2] + 8'h1] = l;
      u_tx_mem_model.mem[a[9:2] + 8'h2] = b;
      u_tx_mem_model.mem[a[9:2] + 8'h3] = k;
   endtask
   task automatic wait_susp(input logic [31:0] d);
      int n;
      n = 0;
      while (susp !== 1'b1 && n < 300) begin
         @(negedge ref_clk_in);
         n++;
      end
      check({31'h0, susp}, 32'h1);
      check(cur_desc, d);
   endtask
   always @(posedge ref_clk_in) begin
      cyc++;
      if (tx_valid && tx_ready) begin
         got_q.push_back(tx_data);
         last_q.push_back(tx_last);
      end
      if (mreq && ack && !mwe && maddr < 32'h100) begin
         rd_q.push_back(maddr);
      end
      if (mreq && !mwe && maddr < 32'h100) begin
         check(cur_buf, maddr);
      end
      if (cyc == 3000) begin
         bad_count++;
         wrap_up();
      end
   end
   initial begin
      for (int i = 0; i < 256; i++) begin
         u_tx_mem_model.mem[i] = 32'hd000_0000 | 32'(i * 4);
      end
      // Every descriptor is filled in before the engine is enabled.
      desc(32'h100, 32'h8010_0000, 32'h8, 32'h40, 32'h200);
      desc(32'h200, 32'h8000_0000, 32'h0004_0004, 32'h60, 32'h70);
      desc(32'h218, 32'h0010_0000, 32'h4, 32'h80, 32'h300);
      u_tx_mem_model.mem[192] = 32'h0;
      tx_ready = 1'b0;
      repeat (12) @(negedge ref_clk_in);
      rst_in = 1'b0;
      list_base_in = 32'h100;
      list_base_wr_in = 1'b1;
      @(negedge ref_clk_in);
      list_base_wr_in = 1'b0;
      repeat (20) @(negedge ref_clk_in);
      check({31'h0, mreq}, 32'h0);
      tx_enable_in = 1'b1;
      wait_susp(32'h218);
      check(32'(rd_q.size()), 32'h4);
      check(rd_q[2], 32'h60);
      check(rd_q[3], 32'h70);
      check(base_q, 32'h100);
      check({31'h0, u_tx_mem_model.mem[64][31]}, 32'h0);
      check({31'h0, u_tx_mem_model.mem[128][31]}, 32'h0);
      flush = 1'b1;
      @(negedge ref_clk_in);
      flush = 1'b0;
      tx_ready = 1'b1;
      repeat (10) @(negedge ref_clk_in);
      check(got_q[0], 32'hd000_0040);
      check(32'(got_q.size()), 32'h1);
      check({31'h0, last_q[0]}, 32'h0);
      got_q.delete();
      last_q.delete();
      wt = 2'h3;
      // Hand the descriptor over, then demand a poll.
      u_tx_mem_model.mem[134] = 32'ha010_0000;
      poll = 1'b1;
      @(negedge ref_clk_in);
      poll = 1'b0;
      repeat (3) @(negedge ref_clk_in);
      wait_susp(32'h300);
      repeat (10) @(negedge ref_clk_in);
      check(got_q[0], 32'hd000_0080);
      check(32'(got_q.size()), 32'h1);
      check({31'h0, last_q[0]}, 32'h1);
      check({31'h0, u_tx_mem_model.mem[134][31]}, 32'h0);
      wrap_up();
   end
endmodule // tx_desc_dma_tb_top
`default_nettype wire
